/* File: pbcr_top.sv */
// Management-frame slave holding the basic control register of five PHY ports
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Bit 15 starts soft reset; hardware clears it when done; zero is normal.
// - Bit 14 turns on MAC loopback at that port; clearing restores forwarding.
// - Looped port turns monitor traffic around at its MAC-to-PHY interface.
// - PHY addresses 1 to 5 loop their own port; each bit independent.
// - With negotiation off, bit 13 forces 100 (one) or 10 (zero); resets one.
// - Bit 12 enables auto-negotiation; resets to one.
// - Bit 11 powers the PHY down; resets to zero.
// - Bit 10 isolates the PHY from its transmit pair; resets to zero.
// - Writing one to bit 9 restarts negotiation; resets to zero.
// - With negotiation off, bit 8 forces full (one) or half duplex; resets zero.
// - Bit 5 picks the crossover algorithm, alternate scheme at reset.
// - Bit 4 forces straight pair use; clear means normal crossed mode.
// - Bit 3 disables automatic crossover; resets to zero.
// - Bit 2 disables far-end fault detection; resets to zero.
module pbcr_top (
	// Clock and reset
	input  wire logic                   mclk_in,
	input  wire logic                   rst_n_in,
	// Management link
	input  wire logic                   mdc_in,
	input  wire logic                   mdio_in,
	output logic                        mdio_out,
	output logic                        mdio_oe_out,
	// Per-port controls towards PHY, negotiation logic and MAC
	output pbcr_pkg::pbcr_ctrl_t [5:1]  ctrl_out,
	output logic                 [5:1]  forced_mode_out,
	output logic                 [5:1]  an_restart_pulse_out
);
	import pbcr_pkg::*;

	function automatic logic [15:0] ctrl_to_word(input pbcr_ctrl_t c);
		logic [15:0] w;
		w = 16'h0000;
		w[BIT_SOFT_RESET]   = c.soft_reset;
		w[BIT_LOOPBACK]     = c.loopback;
		w[BIT_SPEED_100]    = c.speed_100;
		w[BIT_AUTONEG_EN]   = c.autoneg_enable;
		w[BIT_POWER_DOWN]   = c.power_down;
		w[BIT_ISOLATE]      = c.line_isolate;
		w[BIT_AUTONEG_RST]  = c.autoneg_restart;
		w[BIT_FULL_DUPLEX]  = c.full_duplex;
		w[BIT_XOVER_ALG]    = c.crossover_algorithm_select;
		w[BIT_FORCE_STRAIT] = c.force_straight;
		w[BIT_XOVER_DIS]    = c.crossover_disable;
		w[BIT_FEF_DIS]      = c.far_end_fault_disable;
		return w;
	endfunction : ctrl_to_word

	function automatic pbcr_ctrl_t word_to_ctrl(input logic [15:0] w);
		pbcr_ctrl_t c;
		c.soft_reset                 = w[BIT_SOFT_RESET];
		c.loopback                   = w[BIT_LOOPBACK];
		c.speed_100                  = w[BIT_SPEED_100];
		c.autoneg_enable             = w[BIT_AUTONEG_EN];
		c.power_down                 = w[BIT_POWER_DOWN];
		c.line_isolate               = w[BIT_ISOLATE];
		c.autoneg_restart            = w[BIT_AUTONEG_RST];
		c.full_duplex                = w[BIT_FULL_DUPLEX];
		c.crossover_algorithm_select = w[BIT_XOVER_ALG];
		c.force_straight             = w[BIT_FORCE_STRAIT];
		c.crossover_disable          = w[BIT_XOVER_DIS];
		c.far_end_fault_disable      = w[BIT_FEF_DIS];
		return c;
	endfunction : word_to_ctrl

	// Pin synchronisers; the first stage feeds only the second
	logic [1:0]   mdc_sync_q;
	logic [1:0]   mdio_sync_q;
	logic         mdc_prev_q;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mdc_sync_q  <= 2'h0;
			mdio_sync_q <= 2'h3;
			mdc_prev_q  <= 1'b0;
		end else begin
			mdc_sync_q  <= {mdc_sync_q[0], mdc_in};
			mdio_sync_q <= {mdio_sync_q[0], mdio_in};
			mdc_prev_q  <= mdc_sync_q[1];
		end
	end

	wire mdc_rise = mdc_sync_q[1] & ~mdc_prev_q;
	wire mdio_bit = mdio_sync_q[1];

	// Frame state
	pbcr_state_t  state_q, state_d;
	logic [4:0]   cnt_q, cnt_d;
	logic [11:0]  hdr_q, hdr_d;
	logic [15:0]  shr_q, shr_d;
	logic         seen_one_q, seen_one_d;
	logic         oe_q, oe_d;
	logic         out_q, out_d;

	wire [1:0] hdr_op   = hdr_q[11:10];
	wire [4:0] hdr_phy  = hdr_q[9:5];
	wire [4:0] hdr_reg  = hdr_q[4:0];
	wire       hdr_sel  = (hdr_phy >= PHY_ADDR_LO) && (hdr_phy <= PHY_ADDR_HI)
	                      && (hdr_reg == CTRL_REG_ADDR);
	wire       rd_sel   = hdr_sel && (hdr_op == OP_READ);
	wire       wr_sel   = hdr_sel && (hdr_op == OP_WRITE);
	wire [2:0] port_idx = hdr_phy[2:0];

	pbcr_ctrl_t [5:1] ctrl_q;
	logic [15:0]      rd_word;
	logic             wr_commit;
	logic [15:0]      wr_word;

	always_comb begin
		rd_word = 16'h0000;
		for (int p = PORT_LO; p <= PORT_HI; p++) begin
			if (port_idx == 3'(p)) begin
				rd_word = ctrl_to_word(ctrl_q[p]);
			end
		end
	end

	always_comb begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		hdr_d      = hdr_q;
		shr_d      = shr_q;
		seen_one_d = seen_one_q;
		oe_d       = oe_q;
		out_d      = out_q;
		wr_commit  = 1'b0;
		wr_word    = {shr_q[14:0], mdio_bit};
		if (mdc_rise) begin
			case (state_q)
				S_IDLE: begin
					if (mdio_bit) begin
						seen_one_d = 1'b1;
					end else if (seen_one_q) begin
						state_d = S_START;
					end
				end
				S_START: begin
					seen_one_d = 1'b0;
					cnt_d      = 5'h00;
					state_d    = mdio_bit ? S_HDR : S_IDLE;
				end
				S_HDR: begin
					hdr_d = {hdr_q[10:0], mdio_bit};
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == 5'(HDR_BITS - 1)) begin
						state_d = S_TA;
						cnt_d   = 5'h00;
					end
				end
				S_TA: begin
					if (cnt_q == 5'h00) begin
						cnt_d = 5'h01;
						// Second turnaround bit is driven low by us
						if (rd_sel) begin
							oe_d  = 1'b1;
							out_d = 1'b0;
						end
					end else begin
						state_d = S_DATA;
						cnt_d   = 5'h00;
						shr_d   = rd_word;
						if (rd_sel) begin
							out_d = rd_word[15];
						end
					end
				end
				S_DATA: begin
					cnt_d = cnt_q + 5'h01;
					if (rd_sel) begin
						shr_d = {shr_q[14:0], 1'b0};
						out_d = shr_q[14];
					end else begin
						shr_d = wr_word;
					end
					if (cnt_q == 5'(DATA_BITS - 1)) begin
						state_d   = S_IDLE;
						cnt_d     = 5'h00;
						oe_d      = 1'b0;
						out_d     = 1'b0;
						wr_commit = wr_sel;
					end
				end
				default: begin
					state_d = S_IDLE;
					oe_d    = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q    <= S_IDLE;
			cnt_q      <= 5'h00;
			hdr_q      <= 12'h000;
			shr_q      <= 16'h0000;
			seen_one_q <= 1'b0;
			oe_q       <= 1'b0;
			out_q      <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			hdr_q      <= hdr_d;
			shr_q      <= shr_d;
			seen_one_q <= seen_one_d;
			oe_q       <= oe_d;
			out_q      <= out_d;
		end
	end

	assign mdio_out    = out_q;
	assign mdio_oe_out = oe_q;

	// Per-port register storage and soft reset timers
	logic [SRC_W-1:0] srst_cnt_q [5:1];
	logic [5:1]       restart_pulse_q;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int p = PORT_LO; p <= PORT_HI; p++) begin
				ctrl_q[p]          <= word_to_ctrl(CTRL_RESET);
				srst_cnt_q[p]      <= '0;
				restart_pulse_q[p] <= 1'b0;
			end
		end else begin
			for (int p = PORT_LO; p <= PORT_HI; p++) begin
				restart_pulse_q[p] <= 1'b0;
				if (wr_commit && port_idx == 3'(p)) begin
					// Each address writes only its own port
					ctrl_q[p] <= word_to_ctrl(wr_word);
					restart_pulse_q[p] <= wr_word[BIT_AUTONEG_RST];
					if (wr_word[BIT_SOFT_RESET]) begin
						srst_cnt_q[p] <= SRC_W'(SOFT_RST_CYC);
					end
				end else if (srst_cnt_q[p] == SRC_W'(1)) begin
					// Reset done: defaults return and bit 15 clears itself
					ctrl_q[p]     <= word_to_ctrl(CTRL_RESET);
					srst_cnt_q[p] <= '0;
				end else if (srst_cnt_q[p] != '0) begin
					srst_cnt_q[p] <= srst_cnt_q[p] - SRC_W'(1);
				end
			end
		end
	end

	// Loopback bit goes to the port MAC, which turns frames around
	assign ctrl_out             = ctrl_q;
	assign an_restart_pulse_out = restart_pulse_q;

	// Speed and duplex bits only govern while negotiation is off
	always_comb begin
		for (int p = PORT_LO; p <= PORT_HI; p++) begin
			forced_mode_out[p] = ~ctrl_q[p].autoneg_enable;
		end
	end
endmodule : pbcr_top
`default_nettype wire

/* File: pbcr_pkg.sv */
// Package for the per-port PHY basic control register bank
package pbcr_pkg;
	localparam int          PORT_LO       = 1;
	localparam int          PORT_HI       = 5;
	localparam logic [4:0]  CTRL_REG_ADDR = 5'h00;
	localparam logic [4:0]  PHY_ADDR_LO   = 5'h01;
	localparam logic [4:0]  PHY_ADDR_HI   = 5'h05;
	localparam logic [1:0]  OP_READ       = 2'h2;
	localparam logic [1:0]  OP_WRITE      = 2'h1;
	localparam int          HDR_BITS      = 12;
	localparam int          DATA_BITS     = 16;
	// Control word field positions
	localparam int BIT_SOFT_RESET   = 15;
	localparam int BIT_LOOPBACK     = 14;
	localparam int BIT_SPEED_100    = 13;
	localparam int BIT_AUTONEG_EN   = 12;
	localparam int BIT_POWER_DOWN   = 11;
	localparam int BIT_ISOLATE      = 10;
	localparam int BIT_AUTONEG_RST  = 9;
	localparam int BIT_FULL_DUPLEX  = 8;
	localparam int BIT_XOVER_ALG    = 5;
	localparam int BIT_FORCE_STRAIT = 4;
	localparam int BIT_XOVER_DIS    = 3;
	localparam int BIT_FEF_DIS      = 2;
	localparam logic [15:0] CTRL_RESET    = 16'h3020;
	// Soft reset duration
	localparam int          SOFT_RST_NS   = 1000;
	localparam int          CLK_NS        = 40;
	localparam int          SOFT_RST_CYC  = (SOFT_RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int          SRC_W         = 6;

	typedef struct packed {
		logic soft_reset;
		logic loopback;
		logic speed_100;
		logic autoneg_enable;
		logic power_down;
		logic line_isolate;
		logic autoneg_restart;
		logic full_duplex;
		logic crossover_algorithm_select;
		logic force_straight;
		logic crossover_disable;
		logic far_end_fault_disable;
	} pbcr_ctrl_t;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_START = 3'b001,
		S_HDR   = 3'b010,
		S_TA    = 3'b011,
		S_DATA  = 3'b100
	} pbcr_state_t;
endpackage : pbcr_pkg

/* File: pbcr_top_asserts.sv */
// Port-level checks for the PHY basic control register bank
`timescale 1ns/1ps
`default_nettype none
module pbcr_top_asserts (
	input wire logic                        mclk_in,
	input wire logic                        rst_n_in,
	input wire logic                        mdc_in,
	input wire logic                        mdio_in,
	input wire logic                        mdio_out,
	input wire logic                        mdio_oe_out,
	input wire pbcr_pkg::pbcr_ctrl_t [5:1]  ctrl_out,
	input wire logic                 [5:1]  forced_mode_out,
	input wire logic                 [5:1]  an_restart_pulse_out
);
	import pbcr_pkg::*;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	logic [5:1] an_w;
	always_comb for (int i = 1; i <= 5; i++) an_w[i] = ctrl_out[i].autoneg_enable;
	// Turnaround drives zero; checked for four clocks, half an MDC period
	sequence s_turn; (mdio_oe_out && !mdio_out) [*4]; endsequence
	a_forced_mode: assert property (forced_mode_out == ~an_w)
		else $error("forced mode not tied to negotiation enable");
	a_turn_zero: assert property ($rose(mdio_oe_out) |-> s_turn)
		else $error("read turnaround not driven low");
	a_read_len: assert property ($rose(mdio_oe_out) |-> ##[134:138] $fell(mdio_oe_out))
		else $error("read drive length wrong");
	a_read_quiet: assert property (mdio_oe_out |-> $stable(ctrl_out))
		else $error("control changed during read");
	for (genvar p = 1; p <= 5; p++) begin : g_port
		a_pulse_once: assert property (an_restart_pulse_out[p] |=> !an_restart_pulse_out[p])
			else $error("restart pulse too long");
		a_pulse_level: assert property (an_restart_pulse_out[p] |-> ##[0:2] ctrl_out[p].autoneg_restart)
			else $error("restart pulse without restart bit");
		a_srst_clear: assert property ($rose(ctrl_out[p].soft_reset) |-> ##[23:27] $fell(ctrl_out[p].soft_reset))
			else $error("soft reset did not self clear in time");
		a_srst_word: assert property ($fell(ctrl_out[p].soft_reset) |-> ctrl_out[p] == 12'h308)
			else $error("soft reset left wrong control word");
	end
endmodule : pbcr_top_asserts
`default_nettype wire

/* File: pbcr_host.sv */
// Behavioural management controller driving MDC and MDIO
`timescale 1ns/1ps
`default_nettype none
module pbcr_host (
	output logic      mdc_out,
	output logic      mdio_w_out,
	input wire logic  dev_out_in,
	input wire logic  dev_oe_in
);
	import pbcr_pkg::*;
	logic host_en;
	logic host_bit;
	// Pull-up holds the released wire high
	assign mdio_w_out = dev_oe_in ? dev_out_in : (host_en ? host_bit : 1'b1);
	initial begin
		mdc_out = 1'b0;
		host_en = 1'b0;
		host_bit = 1'b1;
	end
	task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
			input logic [15:0] wd, output logic [15:0] rd);
		logic [35:0] v;
		v = {4'hf, 2'b01, op, phy, rg, 2'b10, wd};
		rd = 16'h0000;
		// Keep MDC edges clear of the system clock edge
		#1;
		for (int i = 35; i >= 0; i--) begin
			host_en = !(op == OP_READ && i < 18);
			host_bit = v[i];
			#160 mdc_out = 1'b1;
			if (i < 16) rd = {rd[14:0], mdio_w_out};
			#160 mdc_out = 1'b0;
		end
		host_en = 1'b0;
		#159;
	endtask : xfer
endmodule : pbcr_host
`default_nettype wire

/* File: test_pbcr_top.sv */
// Self-checking bench for the PHY basic control register bank
`timescale 1ns/1ps
`default_nettype none
module test_pbcr_top;
	import pbcr_pkg::*;
	logic              mclk_in = 1'b0;
	logic              rst_n_in = 1'b0;
	wire logic         mdc_w;
	wire logic         mdio_w;
	logic              mdio_out;
	logic              mdio_oe_out;
	pbcr_ctrl_t [5:1]  ctrl_out;
	logic [5:1]        forced_mode_out;
	logic [5:1]        an_restart_pulse_out;
	logic [5:1]        pulse_seen;
	logic [15:0]       rd;
	logic [15:0]       v [1:5] = '{16'h0000, 16'h4000, 16'h7fff, 16'h2100, 16'h4cc4};
	int                fails = 0;
	int                n_tests = 0;
	always #20 mclk_in = ~mclk_in;
	always @(posedge mclk_in) pulse_seen <= rst_n_in ? (pulse_seen | an_restart_pulse_out) : 5'h00;
	pbcr_top dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .mdc_in(mdc_w), .mdio_in(mdio_w),
		.mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out), .ctrl_out(ctrl_out),
		.forced_mode_out(forced_mode_out), .an_restart_pulse_out(an_restart_pulse_out));
	pbcr_host host (.mdc_out(mdc_w), .mdio_w_out(mdio_w), .dev_out_in(mdio_out),
		.dev_oe_in(mdio_oe_out));
	function automatic logic [15:0] cw(input logic [15:0] w);
		return {4'h0, w[15:8], w[5:2]};
	endfunction : cw
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim
	task automatic wr(input logic [4:0] p, input logic [15:0] d);
		host.xfer(OP_WRITE, p, CTRL_REG_ADDR, d, rd);
		repeat (8) @(posedge mclk_in);
	endtask : wr
	task automatic rdc(input logic [4:0] p, input logic [15:0] e);
		host.xfer(OP_READ, p, CTRL_REG_ADDR, 16'h0000, rd);
		chk("read word", e, rd);
	endtask : rdc
	task automatic t_reset;
		for (int p = 1; p <= 5; p++) begin
			rdc(5'(p), 16'h3020);
			chk("reset ctrl", cw(16'h3020), 16'(ctrl_out[p]));
		end
		$display("done reset values");
	endtask : t_reset
	task automatic t_write;
		for (int p = 1; p <= 5; p++) wr(5'(p), v[p]);
		for (int p = 1; p <= 5; p++) begin
			rdc(5'(p), v[p] & 16'h7f3c);
			chk("ctrl", cw(v[p]), 16'(ctrl_out[p]));
			chk("forced", 16'(!v[p][12]), 16'(forced_mode_out[p]));
		end
		chk("restart pulses", 16'h0004, 16'(pulse_seen));
		$display("done write readback");
	endtask : t_write
	task automatic t_soft;
		wr(5'h02, 16'hc000);
		chk("soft bit", 16'h0001, 16'(ctrl_out[2].soft_reset));
		repeat (30) @(posedge mclk_in);
		chk("soft end", cw(16'h3020), 16'(ctrl_out[2]));
		chk("other port", cw(16'h7f3c), 16'(ctrl_out[3]));
		rdc(5'h02, 16'h3020);
		$display("done soft reset");
	endtask : t_soft
	task automatic t_refuse;
		// Address 9 aliases port 1 in its low bits
		host.xfer(OP_WRITE, 5'h09, CTRL_REG_ADDR, 16'hffff, rd);
		host.xfer(OP_WRITE, 5'h01, 5'h01, 16'hffff, rd);
		host.xfer(OP_READ, 5'h06, CTRL_REG_ADDR, 16'h0000, rd);
		chk("unselected read", 16'hffff, rd);
		rdc(5'h01, 16'h0000);
		$display("done refused frames");
	endtask : t_refuse
	initial begin
		repeat (6) @(posedge mclk_in);
		#1 rst_n_in = 1'b1;
		repeat (4) @(posedge mclk_in);
		t_reset;
		t_write;
		t_soft;
		t_refuse;
		end_sim;
	end
	initial begin
		#3000000;
		fails++;
		end_sim;
	end
endmodule : test_pbcr_top
bind pbcr_top pbcr_top_asserts u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .mdc_in(mdc_in),
	.mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out), .ctrl_out(ctrl_out),
	.forced_mode_out(forced_mode_out), .an_restart_pulse_out(an_restart_pulse_out));
`default_nettype wire
